//--- core/crs_pkg.sv
/*
 * Constants shared by the core register set: field positions, reset
 * values, boot fetch addresses and special-register view selectors.
 * Assumes one 250 MHz clock and an asynchronous active-high reset.
 */
package crs_pkg;

  // ==========================================================
  // Widths and register indices
  localparam int          CRS_XLEN          = 32;
  localparam int          CRS_NUM_GPR       = 13;
  localparam logic [3:0]  CRS_IDX_SP        = 4'hd;
  localparam logic [3:0]  CRS_IDX_LINK      = 4'he;
  localparam logic [3:0]  CRS_IDX_IP        = 4'hf;

  // ==========================================================
  // Status and stack control word field positions and widths
  localparam int          CRS_FLAG_LSB      = 28;
  localparam int          CRS_TBIT_POS      = 24;
  localparam int          CRS_EXC_W         = 6;
  localparam int          CRS_CTRL_SEL_POS  = 1;

  // ==========================================================
  // Reset values and boot vector addresses
  localparam logic [31:0] CRS_VEC_SP_ADDR   = 32'h0000_0000;
  localparam logic [31:0] CRS_VEC_IP_ADDR   = 32'h0000_0004;
  localparam logic [5:0]  CRS_EXC_RST       = 6'h00;
  localparam logic        CRS_PMASK_RST     = 1'b0;
  localparam logic        CRS_SEL_RST       = 1'b0;
  localparam logic [3:0]  CRS_FLAGS_RST     = 4'h0;
  localparam logic        CRS_TBIT_RST      = 1'b0;
  localparam logic [5:0]  CRS_EXC_THREAD    = 6'h00;

  // ==========================================================
  // Special-register move selectors
  localparam logic [3:0]  SEL_STATUS_ALL    = 4'h0;
  localparam logic [3:0]  SEL_COND_FLAGS    = 4'h1;
  localparam logic [3:0]  SEL_APP_INTR      = 4'h2;
  localparam logic [3:0]  SEL_APP_EXEC      = 4'h3;
  localparam logic [3:0]  SEL_EXEC_INTR     = 4'h4;
  localparam logic [3:0]  SEL_EXC_NUM       = 4'h5;
  localparam logic [3:0]  SEL_EXEC_STATE    = 4'h6;
  localparam logic [3:0]  SEL_MAIN_STACK    = 4'h7;
  localparam logic [3:0]  SEL_PROC_STACK    = 4'h8;
  localparam logic [3:0]  SEL_PRIO_MASK     = 4'h9;
  localparam logic [3:0]  SEL_STACK_CTRL    = 4'ha;

  // Boot sequence states
  typedef enum logic [1:0] {
    CRS_BOOT_SP,
    CRS_BOOT_IP,
    CRS_RUN
  } crs_boot_e;

endpackage

//--- core/crs_gpr_mem.sv
/*
 * Thirteen 32-bit general data registers with one write port and one
 * registered read port. Addresses of 13 and above write nothing and read zero.
 */
`timescale 1ns/10ps

module crs_gpr_mem
  import crs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  waddr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  raddr_i,
  output logic      [31:0] rdata_o
);

  // ==========================================================
  // Storage, no reset: contents are undefined after reset
  logic [31:0] mem_q [CRS_NUM_GPR];
  wire         wr_hit = we_i && (waddr_i < 4'(CRS_NUM_GPR));
  wire         rd_hit = raddr_i < 4'(CRS_NUM_GPR);

  // Write port
  always_ff @(posedge clk_i) begin
    if (wr_hit) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // Registered read keeps the data output on a flop
  always_ff @(posedge clk_i) begin
    rdata_o <= rd_hit ? mem_q[raddr_i] : 32'h0000_0000;
  end

endmodule

//--- core/crs_core_regs.sv
/*
 * Core register set: general registers, banked stack pointers, link,
 * instruction pointer, status word, priority mask and stack select.
 * Assumes the decoder, interrupt controller and memory system outside
 * drive the request ports, all on clk_i.
 */
`timescale 1ns/10ps

module crs_core_regs
  import crs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  output logic             vec_req_o,
  output logic      [31:0] vec_addr_o,
  input  wire logic        vec_valid_i,
  input  wire logic [31:0] vec_data_i,
  output logic             ready_o,
  input  wire logic        gpr_we_i,
  input  wire logic [3:0]  gpr_waddr_i,
  input  wire logic [31:0] gpr_wdata_i,
  input  wire logic [3:0]  gpr_raddr_i,
  output logic      [31:0] gpr_rdata_o,
  input  wire logic        ip_we_i,
  input  wire logic        ip_exch_i,
  input  wire logic [31:0] ip_wdata_i,
  output logic      [31:0] ip_o,
  input  wire logic        flags_we_i,
  input  wire logic [3:0]  flags_i,
  output logic      [3:0]  flags_o,
  input  wire logic [3:0]  sreg_sel_i,
  input  wire logic        sreg_we_i,
  input  wire logic [31:0] sreg_wdata_i,
  input  wire logic        dbg_i,
  output logic      [31:0] sreg_rdata_o,
  input  wire logic        mask_op_i,
  input  wire logic        mask_val_i,
  output logic             prio_mask_o,
  input  wire logic        cfg_exc_req_i,
  output logic             cfg_exc_allow_o,
  input  wire logic        exec_i,
  output logic             hard_fault_o,
  input  wire logic        multi_start_i,
  input  wire logic        multi_busy_i,
  input  wire logic        exc_entry_i,
  input  wire logic [5:0]  exc_num_i,
  input  wire logic [31:0] exc_vector_i,
  input  wire logic [31:0] exc_link_i,
  output logic      [31:0] stacked_psr_o,
  output logic      [31:0] stacked_ret_o,
  output logic             multi_abandon_o,
  input  wire logic        exc_return_i,
  input  wire logic [31:0] ret_psr_i,
  input  wire logic        ret_thread_i,
  input  wire logic        ret_use_proc_i,
  output logic             handler_mode_o,
  output logic             use_proc_stack_o,
  output logic [5:0]       exc_num_o
);

  // ==========================================================
  // State
  crs_boot_e   boot_q;
  logic [31:0] main_stack_ptr_q;
  logic [31:0] process_stack_ptr_q;
  logic [31:0] return_link_reg_q;
  logic [31:0] instruction_pointer_q;
  logic [3:0]  flags_q;
  logic [5:0]  exc_num_q;
  logic        t_bit_q;
  logic        prio_mask_q;
  logic        stack_sel_q;
  logic [31:0] restart_ip_q;
  logic [31:0] hi_rdata_q;
  logic        hi_rsel_q;
  logic [31:0] mem_rdata;

  // ==========================================================
  // Decode
  wire run      = boot_q == CRS_RUN;
  wire quiet    = run && !exc_entry_i && !exc_return_i;
  wire handler  = exc_num_q != CRS_EXC_THREAD;
  wire use_proc = stack_sel_q && !handler;
  wire boot_sp  = boot_q == CRS_BOOT_SP && vec_valid_i;
  wire boot_ip  = boot_q == CRS_BOOT_IP && vec_valid_i;

  // Status views: which fields a selector covers
  wire v_app = sreg_sel_i == SEL_STATUS_ALL || sreg_sel_i == SEL_COND_FLAGS
            || sreg_sel_i == SEL_APP_INTR || sreg_sel_i == SEL_APP_EXEC;
  wire v_int = sreg_sel_i == SEL_STATUS_ALL || sreg_sel_i == SEL_APP_INTR
            || sreg_sel_i == SEL_EXEC_INTR || sreg_sel_i == SEL_EXC_NUM;
  wire v_exe = sreg_sel_i == SEL_STATUS_ALL || sreg_sel_i == SEL_APP_EXEC
            || sreg_sel_i == SEL_EXEC_INTR || sreg_sel_i == SEL_EXEC_STATE;

  // Move writes; exception number and state bit only by debug access
  wire mv         = sreg_we_i && quiet;
  wire wr_flags   = mv && v_app;
  wire wr_excnum  = mv && v_int && dbg_i;
  wire wr_tbit    = mv && v_exe && dbg_i;
  wire wr_main    = mv && sreg_sel_i == SEL_MAIN_STACK;
  wire wr_proc    = mv && sreg_sel_i == SEL_PROC_STACK;
  wire wr_pmask   = mv && sreg_sel_i == SEL_PRIO_MASK;
  wire wr_ctrl    = mv && sreg_sel_i == SEL_STACK_CTRL && !handler;
  wire gw_sp      = gpr_we_i && quiet && gpr_waddr_i == CRS_IDX_SP;
  wire gw_link    = gpr_we_i && quiet && gpr_waddr_i == CRS_IDX_LINK;
  wire gw_ip      = gpr_we_i && quiet && gpr_waddr_i == CRS_IDX_IP;

  // Assembled status word fields, reserved bits zero
  wire [31:0] f_app  = {flags_q, 28'h000_0000};
  wire [31:0] f_int  = {26'h000_0000, exc_num_q};
  wire [31:0] f_exe  = {7'h00, t_bit_q, 24'h00_0000};
  wire [31:0] psr_full = f_app | f_int | f_exe;
  wire [31:0] f_exe_rd = dbg_i ? f_exe : 32'h0000_0000;
  wire [31:0] ctrl_rd  = {30'h0000_0000, use_proc, 1'b0};
  wire [31:0] psr_rd   = (v_app ? f_app : 32'h0) | (v_int ? f_int : 32'h0)
                       | (v_exe ? f_exe_rd : 32'h0);

  // Special-register read mux, unknown selectors read zero
  wire [31:0] sreg_rd_d =
      (sreg_sel_i == SEL_MAIN_STACK) ? main_stack_ptr_q :
      (sreg_sel_i == SEL_PROC_STACK) ? process_stack_ptr_q :
      (sreg_sel_i == SEL_PRIO_MASK)  ? {31'h0000_0000, prio_mask_q} :
      (sreg_sel_i == SEL_STACK_CTRL) ? ctrl_rd : psr_rd;

  // Register 13 view follows the active pointer
  wire [31:0] active_sp = use_proc ? process_stack_ptr_q : main_stack_ptr_q;
  wire [31:0] hi_rd_d   = (gpr_raddr_i == CRS_IDX_SP)   ? active_sp :
                          (gpr_raddr_i == CRS_IDX_LINK) ? return_link_reg_q :
                                                          instruction_pointer_q;
  wire        hi_rsel_d = gpr_raddr_i >= CRS_IDX_SP;

  // Return address skips back to the start of an interrupted multi-transfer
  wire [31:0] ret_addr = multi_busy_i ? restart_ip_q : instruction_pointer_q;

  // ==========================================================
  // General registers 0..12
  crs_gpr_mem u_gpr (
    .clk_i   (clk_i),
    .we_i    (gpr_we_i && quiet),
    .waddr_i (gpr_waddr_i),
    .wdata_i (gpr_wdata_i),
    .raddr_i (gpr_raddr_i),
    .rdata_o (mem_rdata)
  );

  // ==========================================================
  // Boot fetch sequence: stack word, then reset vector
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_q <= CRS_BOOT_SP;
    end else begin
      unique case (boot_q)
        CRS_BOOT_SP: if (vec_valid_i) boot_q <= CRS_BOOT_IP;
        CRS_BOOT_IP: if (vec_valid_i) boot_q <= CRS_RUN;
        CRS_RUN:     boot_q <= CRS_RUN;
      endcase
    end
  end

  // Main stack pointer: boot load, moves, register 13 writes while the main pointer is active
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      main_stack_ptr_q <= CRS_VEC_SP_ADDR;
    end else if (boot_sp) begin
      main_stack_ptr_q <= vec_data_i;
    end else if (wr_main || (gw_sp && !use_proc)) begin
      main_stack_ptr_q <= wr_main ? sreg_wdata_i : gpr_wdata_i;
    end
  end

  // Process stack pointer and link: no reset, contents undefined
  always_ff @(posedge clk_i) begin
    if (wr_proc || (gw_sp && use_proc)) begin
      process_stack_ptr_q <= wr_proc ? sreg_wdata_i : gpr_wdata_i;
    end
    if (run && exc_entry_i) begin
      return_link_reg_q <= exc_link_i;
    end else if (gw_link) begin
      return_link_reg_q <= gpr_wdata_i;
    end
  end

  // Instruction pointer; bit 0 never stored, it steers the state bit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      instruction_pointer_q <= CRS_VEC_IP_ADDR;
    end else if (boot_ip) begin
      instruction_pointer_q <= {vec_data_i[31:1], 1'b0};
    end else if (run && exc_entry_i) begin
      instruction_pointer_q <= {exc_vector_i[31:1], 1'b0};
    end else if (quiet && ip_we_i) begin
      instruction_pointer_q <= {ip_wdata_i[31:1], 1'b0};
    end else if (gw_ip) begin
      instruction_pointer_q <= {gpr_wdata_i[31:1], 1'b0};
    end
  end

  // Restart point latched when a multi-transfer begins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      restart_ip_q <= CRS_VEC_IP_ADDR;
    end else if (quiet && multi_start_i) begin
      restart_ip_q <= instruction_pointer_q;
    end
  end

  // Condition flags; a move wins over an ALU update in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q <= CRS_FLAGS_RST;
    end else if (run && exc_return_i) begin
      flags_q <= ret_psr_i[31:CRS_FLAG_LSB];
    end else if (wr_flags) begin
      flags_q <= sreg_wdata_i[31:CRS_FLAG_LSB];
    end else if (quiet && flags_we_i) begin
      flags_q <= flags_i;
    end
  end

  // Exception number: thread at reset, set on entry, restored on return
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      exc_num_q <= CRS_EXC_RST;
    end else if (run && exc_entry_i) begin
      exc_num_q <= exc_num_i;
    end else if (run && exc_return_i) begin
      exc_num_q <= ret_thread_i ? CRS_EXC_THREAD : ret_psr_i[CRS_EXC_W-1:0];
    end else if (wr_excnum) begin
      exc_num_q <= sreg_wdata_i[CRS_EXC_W-1:0];
    end
  end

  // State bit: boot, entry, exchange branch and register 15 loads copy bit 0; return and debug moves take bit 24
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      t_bit_q <= CRS_TBIT_RST;
    end else if (boot_ip) begin
      t_bit_q <= vec_data_i[0];
    end else if (run && exc_entry_i) begin
      t_bit_q <= exc_vector_i[0];
    end else if (run && exc_return_i) begin
      t_bit_q <= ret_psr_i[CRS_TBIT_POS];
    end else if (quiet && ip_we_i && ip_exch_i) begin
      t_bit_q <= ip_wdata_i[0];
    end else if (gw_ip && !ip_we_i) begin
      t_bit_q <= gpr_wdata_i[0];
    end else if (wr_tbit) begin
      t_bit_q <= sreg_wdata_i[CRS_TBIT_POS];
    end
  end

  // Priority mask and stack select
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prio_mask_q <= CRS_PMASK_RST;
      stack_sel_q <= CRS_SEL_RST;
    end else begin
      if (wr_pmask) begin
        prio_mask_q <= sreg_wdata_i[0];
      end else if (quiet && mask_op_i) begin
        prio_mask_q <= mask_val_i;
      end
      if (run && exc_entry_i) begin
        stack_sel_q <= 1'b0;
      end else if (run && exc_return_i) begin
        stack_sel_q <= ret_thread_i && ret_use_proc_i;
      end else if (wr_ctrl) begin
        stack_sel_q <= sreg_wdata_i[CRS_CTRL_SEL_POS];
      end
    end
  end

  // Read data, stacking copies and the fault pulse on flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sreg_rdata_o    <= 32'h0000_0000;
      hi_rdata_q      <= 32'h0000_0000;
      hi_rsel_q       <= 1'b0;
      stacked_psr_o   <= 32'h0000_0000;
      stacked_ret_o   <= 32'h0000_0000;
      multi_abandon_o <= 1'b0;
      hard_fault_o    <= 1'b0;
    end else begin
      sreg_rdata_o    <= sreg_rd_d;
      hi_rdata_q      <= hi_rd_d;
      hi_rsel_q       <= hi_rsel_d;
      multi_abandon_o <= run && exc_entry_i && multi_busy_i;
      hard_fault_o    <= quiet && exec_i && !t_bit_q;
      if (run && exc_entry_i) begin
        stacked_psr_o <= psr_full;
        stacked_ret_o <= ret_addr;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign vec_req_o        = !run;
  assign vec_addr_o       = (boot_q == CRS_BOOT_SP) ? CRS_VEC_SP_ADDR : CRS_VEC_IP_ADDR;
  assign ready_o          = run;
  assign gpr_rdata_o      = hi_rsel_q ? hi_rdata_q : mem_rdata;
  assign ip_o             = instruction_pointer_q;
  assign flags_o          = flags_q;
  assign prio_mask_o      = prio_mask_q;
  assign cfg_exc_allow_o  = cfg_exc_req_i && !prio_mask_q;
  assign handler_mode_o   = handler;
  assign use_proc_stack_o = use_proc;
  assign exc_num_o        = exc_num_q;

  // ==========================================================
  // Checks
  boot_sp_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    boot_sp |=> main_stack_ptr_q == $past(vec_data_i))
    else $error("main stack pointer not loaded from vector word");
  boot_ip_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    boot_ip |=> ip_o == {$past(vec_data_i[31:1]), 1'b0} && ready_o)
    else $error("instruction pointer not loaded from reset vector");
  boot_tbit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    boot_ip |=> t_bit_q == $past(vec_data_i[0]))
    else $error("state bit not copied from vector bit 0");
  excnum_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mv && v_int && !dbg_i |=> $stable(exc_num_q))
    else $error("exception number changed by software move");
  exec_read_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sreg_sel_i == SEL_EXEC_STATE && !dbg_i |=> sreg_rdata_o == 32'h0)
    else $error("execution state read not zero");
  branch_tclear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    quiet && ip_we_i && ip_exch_i && !ip_wdata_i[0] |=> !t_bit_q)
    else $error("state bit not cleared by interworking branch");
  tbit_fault_a: assert property (@(posedge clk_i) disable iff (rst_i)
    quiet && exec_i && !t_bit_q |=> hard_fault_o)
    else $error("no hard fault for cleared state bit");
  mask_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    prio_mask_o |-> !cfg_exc_allow_o)
    else $error("configurable exception passed while masked");
  stack_psr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    run && exc_entry_i |=> stacked_psr_o[CRS_TBIT_POS] == $past(t_bit_q)
      && stacked_psr_o[5:0] == $past(exc_num_q))
    else $error("stacked status word wrong");
  handler_main_a: assert property (@(posedge clk_i) disable iff (rst_i)
    handler_mode_o |-> !use_proc_stack_o)
    else $error("process stack used in handler mode");
  ctrl_handler_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mv && sreg_sel_i == SEL_STACK_CTRL && handler |=> $stable(stack_sel_q))
    else $error("stack select written in handler mode");
  restart_ret_a: assert property (@(posedge clk_i) disable iff (rst_i)
    run && exc_entry_i && multi_busy_i |=> multi_abandon_o
      && stacked_ret_o == $past(restart_ip_q))
    else $error("multi-transfer not restarted from its start");
  entry_c:  cover property (@(posedge clk_i) disable iff (rst_i) run && exc_entry_i);
  return_c: cover property (@(posedge clk_i) disable iff (rst_i)
    run && exc_return_i && ret_use_proc_i && ret_thread_i);
  fault_c:  cover property (@(posedge clk_i) disable iff (rst_i) hard_fault_o);

endmodule

//--- tb/tb_crs_core_regs.sv
/*
 * Self-checking bench for crs_core_regs: boot fetch, moves, mask,
 * exception entry and return, state-bit fault.
 * Assumes crs_pkg is compiled first; inputs change at falling edges.
 */
`timescale 1ns/10ps
module tb_crs_core_regs
  import crs_pkg::*;
;
  // ==========================================================
  // Signals
  logic clk_i, rst_i, vec_valid_i, gpr_we_i, ip_we_i, ip_exch_i, flags_we_i, sreg_we_i, dbg_i;
  logic mask_op_i, mask_val_i, cfg_exc_req_i, exec_i, multi_start_i, multi_busy_i;
  logic exc_entry_i, exc_return_i, ret_thread_i, ret_use_proc_i, vec_req_o, ready_o;
  logic prio_mask_o, cfg_exc_allow_o, hard_fault_o, multi_abandon_o, handler_mode_o;
  logic use_proc_stack_o;
  logic [3:0]  gpr_waddr_i, gpr_raddr_i, flags_i, flags_o, sreg_sel_i;
  logic [5:0]  exc_num_i, exc_num_o;
  logic [31:0] vec_data_i, gpr_wdata_i, ip_wdata_i, sreg_wdata_i, exc_vector_i, exc_link_i;
  logic [31:0] ret_psr_i, vec_addr_o, gpr_rdata_o, ip_o, sreg_rdata_o, stacked_psr_o;
  logic [31:0] stacked_ret_o;
  int          error_cnt, tests_run, cyc;

  crs_core_regs u_crs_core_regs (.clk_i, .rst_i, .vec_req_o, .vec_addr_o, .vec_valid_i,
    .vec_data_i, .ready_o, .gpr_we_i, .gpr_waddr_i, .gpr_wdata_i, .gpr_raddr_i, .gpr_rdata_o,
    .ip_we_i, .ip_exch_i, .ip_wdata_i, .ip_o, .flags_we_i, .flags_i, .flags_o, .sreg_sel_i,
    .sreg_we_i, .sreg_wdata_i, .dbg_i, .sreg_rdata_o, .mask_op_i, .mask_val_i, .prio_mask_o,
    .cfg_exc_req_i, .cfg_exc_allow_o, .exec_i, .hard_fault_o, .multi_start_i, .multi_busy_i,
    .exc_entry_i, .exc_num_i, .exc_vector_i, .exc_link_i, .stacked_psr_o, .stacked_ret_o,
    .multi_abandon_o, .exc_return_i, .ret_psr_i, .ret_thread_i, .ret_use_proc_i,
    .handler_mode_o, .use_proc_stack_o, .exc_num_o);

  // ==========================================================
  // Clock, hang guard and shared tasks
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Whole run needs well under a hundred cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic tick();
    @(negedge clk_i);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Move-to write: strobe held for exactly one rising edge
  task automatic sw(input logic [3:0] s, input logic [31:0] d);
    sreg_sel_i = s; sreg_wdata_i = d; sreg_we_i = 1'b1; tick(); sreg_we_i = 1'b0; tick();
  endtask
  task automatic rd(input logic [3:0] s, input logic [31:0] e);
    sreg_sel_i = s; tick(); chk(sreg_rdata_o, e);
  endtask
  task automatic stop_test();
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_boot();
    tick(); chk(vec_addr_o, CRS_VEC_SP_ADDR); chk(handler_mode_o, 1'b0);
    tick(); rst_i = 1'b0; vec_valid_i = 1'b1; vec_data_i = 32'h2000_0400;
    tick(); chk(vec_addr_o, CRS_VEC_IP_ADDR);
    vec_data_i = 32'h0000_0101;
    tick(); vec_valid_i = 1'b0; chk(ready_o, 1'b1); chk(ip_o, 32'h0000_0100);
    chk(prio_mask_o, 1'b0);
    rd(SEL_MAIN_STACK, 32'h2000_0400);
  endtask
  task automatic t_regs();
    gpr_we_i = 1'b1; gpr_waddr_i = 4'h3; gpr_wdata_i = 32'h1234_5678; gpr_raddr_i = 4'h3;
    flags_we_i = 1'b1; flags_i = 4'h5; tick(); gpr_we_i = 1'b0; flags_we_i = 1'b0; tick();
    chk(gpr_rdata_o, 32'h1234_5678); chk(flags_o, 4'h5);
    sw(SEL_STATUS_ALL, 32'hf100_003f); chk(flags_o, 4'hf); chk(exc_num_o, 6'h00);
    rd(SEL_STATUS_ALL, 32'hf000_0000);
    rd(SEL_COND_FLAGS, 32'hf000_0000);
  endtask
  task automatic t_mask();
    cfg_exc_req_i = 1'b1; sw(SEL_PRIO_MASK, 32'hffff_ffff);
    chk(prio_mask_o, 1'b1); chk(cfg_exc_allow_o, 1'b0); rd(SEL_PRIO_MASK, 32'h1);
    mask_op_i = 1'b1; mask_val_i = 1'b0; tick(); mask_op_i = 1'b0; tick();
    chk(cfg_exc_allow_o, 1'b1);
  endtask
  task automatic t_exc();
    sw(SEL_STACK_CTRL, 32'h2); chk(use_proc_stack_o, 1'b1);
    multi_start_i = 1'b1; tick(); multi_start_i = 1'b0; multi_busy_i = 1'b1;
    exc_entry_i = 1'b1; exc_num_i = 6'h10; exc_vector_i = 32'h201; exc_link_i = 32'hffff_fff9;
    tick(); exc_entry_i = 1'b0; multi_busy_i = 1'b0;
    chk(exc_num_o, 6'h10); chk(handler_mode_o, 1'b1); chk(ip_o, 32'h200);
    chk(use_proc_stack_o, 1'b0); chk(stacked_psr_o, 32'hf100_0000);
    chk(multi_abandon_o, 1'b1); chk(stacked_ret_o, 32'h100);
    sw(SEL_STACK_CTRL, 32'h2); chk(use_proc_stack_o, 1'b0);
    rd(SEL_STACK_CTRL, 32'h0);
    exc_return_i = 1'b1; ret_psr_i = 32'h2100_0000; ret_thread_i = 1'b1; ret_use_proc_i = 1'b1;
    tick(); exc_return_i = 1'b0;
    chk(exc_num_o, 6'h00); chk(use_proc_stack_o, 1'b1); chk(flags_o, 4'h2);
  endtask
  task automatic t_tbit();
    ip_we_i = 1'b1; ip_exch_i = 1'b1; ip_wdata_i = 32'h300; tick();
    ip_we_i = 1'b0; ip_exch_i = 1'b0; exec_i = 1'b1; tick(); exec_i = 1'b0;
    chk(ip_o, 32'h300); chk(hard_fault_o, 1'b1);
  endtask
  // Pop into register 15 sets the state bit again; debug sees it
  task automatic t_dbg();
    gpr_we_i = 1'b1; gpr_waddr_i = 4'hf; gpr_wdata_i = 32'h0000_0401; tick();
    gpr_we_i = 1'b0; dbg_i = 1'b1;
    chk(ip_o, 32'h0000_0400);
    rd(SEL_EXEC_STATE, 32'h0100_0000);
    dbg_i = 1'b0; chk(vec_req_o, 1'b0);
  endtask

  // ==========================================================
  // Main sequence; every input defined at time zero
  initial begin
    {vec_valid_i, gpr_we_i, ip_we_i, ip_exch_i, flags_we_i, sreg_we_i, dbg_i} = '0;
    {mask_op_i, mask_val_i, cfg_exc_req_i, exec_i, multi_start_i, multi_busy_i} = '0;
    {exc_entry_i, exc_return_i, ret_thread_i, ret_use_proc_i} = '0;
    {gpr_waddr_i, gpr_raddr_i, flags_i, sreg_sel_i, exc_num_i} = '0;
    {vec_data_i, gpr_wdata_i, ip_wdata_i, sreg_wdata_i, exc_vector_i} = '0;
    {exc_link_i, ret_psr_i} = '0;
    error_cnt = 0; tests_run = 0; cyc = 0; rst_i = 1'b1;
    t_boot(); t_regs(); t_mask(); t_exc(); t_tbit(); t_dbg();
    stop_test();
  end
endmodule
